// ===== hdl/pmu_code_adjust.sv
// Purpose: Linear regulator target code from a rail target and offset.
// Assumes: One code step equals the rail step size.
// Notes: Saturates at the code range ends rather than wrapping.
`timescale 1ns/1ns
`default_nettype none
module pmu_code_adjust
  import pmu_pkg::*;
#(
  parameter int W = TRG_W
) (
  // Code in
  input wire logic [W-1:0] target,
  input wire logic [OFS_W-1:0] offsetSel,
  // Code out
  output logic [W-1:0] linear
);
  wire atMin = (target == '0);
  wire atMax = (target == '1);
  wire [W-1:0] down = atMin ? target : target - W'(1);
  wire [W-1:0] up = atMax ? target : target + W'(1);

  // Unknown selector codes fall back to equal
  assign linear = (offsetSel == OFS_BELOW) ? down :
                  (offsetSel == OFS_ABOVE) ? up : target;
endmodule
`default_nettype wire

// ===== hdl/pmu_rail_ctrl.sv
// Purpose: Supply detection, rail targets, memory rail and brownout shutdown.
// Assumes: Comparator and request pins are asynchronous to sys_clk.
// Notes: APB answers with one wait-free access cycle; pready is registered.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module pmu_rail_ctrl
  import pmu_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparators and requests from pins
  input wire logic supplyValidRaw,
  input wire logic supplyAboveIoRaw,
  input wire logic [NRAIL-1:0] railBrownoutRaw,
  input wire logic batteryBrownoutRaw,
  input wire logic hwResetReqRaw,
  // Watchdog, same clock domain
  input wire logic watchdogReset,
  // Supply detection
  output logic supplyCmpPowerUp,
  output logic [VTH_W-1:0] supplyValidThresholdSelect,
  output logic converterOn,
  // Core, analog and io rails
  output logic [NRAIL-1:0] linearRegulatorOn,
  output logic [NRAIL*TRG_W-1:0] railTargetCode,
  output logic [NRAIL*TRG_W-1:0] linearTargetCode,
  output logic [NRAIL*TRG_W-1:0] railBrownoutCode,
  // Memory rail
  output logic [TRG_W-1:0] memoryRailTargetCode,
  output logic memoryRailOn,
  output logic memoryRailPulldown,
  output logic inrushLimiterOn,
  // Four-two rail and battery
  output logic [FTT_W-1:0] fourPointTwoTargetCode,
  output logic [BBL_W-1:0] batteryBrownoutLevel,
  // Power-down and reset requests
  output logic powerDownReq,
  output logic deviceResetReq
);
  // Software-held state
  logic cmpPowerUp;
  logic [VTH_W-1:0] validThresh;
  logic detectMethod;
  logic runWithSupply;
  logic brownoutShutdownEn;
  logic [TRG_W-1:0] railTrg [NRAIL];
  logic [OFS_W-1:0] railOfs [NRAIL];
  logic [MGN_W-1:0] railMgn [NRAIL];
  logic [NRAIL-1:0] railLin;
  logic [TRG_W-1:0] memTrg;
  logic memPulldown;
  logic memLinOn;
  logic memIlimit;
  logic [FTT_W-1:0] fttTrg;
  logic [BBL_W-1:0] battLevel;
  logic powerDownOff;
  // Hardware state
  logic fivePresent;
  logic [NRAIL-1:0] railBoFlag;
  logic battBoFlag;

  // Synchronised pin levels
  // Comparators cross into sys_clk through two flops first
  logic [NRAIL+3:0] syncOut;
  wire validSync = syncOut[0];
  wire aboveIoSync = syncOut[1];
  wire [NRAIL-1:0] railBoSync = syncOut[NRAIL+1:2];
  wire battBoSync = syncOut[NRAIL+2];
  wire hwResetSync = syncOut[NRAIL+3];

  pmu_sync #(.W(NRAIL+4)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .async({hwResetReqRaw, batteryBrownoutRaw, railBrownoutRaw, supplyAboveIoRaw, supplyValidRaw}),
    .synced(syncOut)
  );

  // APB decode
  // Only setup is decoded, so every access answers in one cycle
  wire setupPh = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrEn = accessDone & pwrite;
  wire hitSupply = (paddr == ADDR_SUPPLY);
  wire hitMemory = (paddr == ADDR_MEMORY);
  wire hitFourTwo = (paddr == ADDR_FOURTWO);
  wire hitBattery = (paddr == ADDR_BATTERY);
  wire hitShutdown = (paddr == ADDR_SHUTDOWN);
  wire hitStatus = (paddr == ADDR_STATUS);
  wire [NRAIL-1:0] hitRail;
  assign hitRail[0] = (paddr == ADDR_CORE);
  assign hitRail[1] = (paddr == ADDR_ANALOG);
  assign hitRail[2] = (paddr == ADDR_IO);
  wire hitAny = hitSupply | (|hitRail) | hitMemory | hitFourTwo | hitBattery | hitShutdown | hitStatus;
  // A wrong key is dropped silently; a stray word keeps the switch
  wire keyOk = (pwdata[SHDN_KEY_LSB +: 16] == SHDN_KEY);
  wire shutdownWr = wrEn & hitShutdown & keyOk;

  // Supply presence as seen by the converter control
  // An unpowered comparator reads as no supply
  // Keeps the converter running until the comparator is powered, when detectMethod selects it
  wire validSeen = cmpPowerUp & validSync;
  wire next_fivePresent = detectMethod ? validSeen : aboveIoSync;

  // Status clear and set; a set in the clearing cycle survives
  // Sticky, so a short brownout is never missed
  wire statusClr = wrEn & hitStatus;
  wire [NRAIL-1:0] next_railBoFlag =
    (railBoFlag & ~(statusClr ? pwdata[STA_RAIL_BO +: NRAIL] : {NRAIL{1'b0}})) | railBoSync;
  wire next_battBoFlag = (battBoFlag & ~(statusClr & pwdata[STA_BATT_BO])) | battBoSync;

  // Hardware power-down and reset gating
  // Watchdog bypasses the switch so a hung system can be reset
  // Limitation: one enable for all brownouts, no supply masking
  wire anyBrownout = (|railBoSync) | battBoSync;
  wire next_powerDownReq = ~powerDownOff & brownoutShutdownEn & anyBrownout;
  wire next_deviceResetReq = watchdogReset | (~powerDownOff & hwResetSync);

  // Converter yields to a present supply unless told to run
  wire next_converterOn = ~fivePresent | runWithSupply;
  wire [NRAIL-1:0] next_linearRegulatorOn = fivePresent ? (~{NRAIL{runWithSupply}} | railLin) : railLin;

  // Read data
  // Unmapped addresses read as zero
  logic [31:0] rdRail [NRAIL];
  logic [31:0] rdMux;

  always_comb begin
    rdMux = RST_ZERO;
    if (hitSupply) begin
      rdMux[SUP_CMP_PWR] = cmpPowerUp;
      rdMux[SUP_VTH_LSB +: VTH_W] = validThresh;
      rdMux[SUP_DET_METHOD] = detectMethod;
      rdMux[SUP_RUN_CONV] = runWithSupply;
      rdMux[SUP_BO_SHDN] = brownoutShutdownEn;
    end else if (hitRail[0]) begin
      rdMux = rdRail[0];
    end else if (hitRail[1]) begin
      rdMux = rdRail[1];
    end else if (hitRail[2]) begin
      rdMux = rdRail[2];
    end else if (hitMemory) begin
      rdMux[RAIL_TRG_LSB +: TRG_W] = memTrg;
      rdMux[MEM_PULLDOWN] = memPulldown;
      rdMux[MEM_LIN_ON] = memLinOn;
      rdMux[MEM_ILIMIT] = memIlimit;
    end else if (hitFourTwo) begin
      rdMux[FTT_W-1:0] = fttTrg;
    end else if (hitBattery) begin
      rdMux[BBL_W-1:0] = battLevel;
    end else if (hitShutdown) begin
      rdMux[SHDN_PD_OFF] = powerDownOff;
    end else if (hitStatus) begin
      rdMux[STA_SUPPLY] = fivePresent;
      rdMux[STA_CONV] = converterOn;
      rdMux[STA_RAIL_BO +: NRAIL] = railBoFlag;
      rdMux[STA_BATT_BO] = battBoFlag;
    end
  end

  // Bus answer: registered one cycle after setup
  // Read data are zero outside the answer cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_ZERO;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh & ~hitAny;
      prdata <= (setupPh & ~pwrite) ? rdMux : RST_ZERO;
    end
  end

  // Supply control register
  // Method and run bit act through the hardware state below
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmpPowerUp <= 1'b0;
      validThresh <= '0;
      detectMethod <= 1'b0;
      runWithSupply <= 1'b0;
      brownoutShutdownEn <= 1'b0;
    end else if (wrEn && hitSupply) begin
      cmpPowerUp <= pwdata[SUP_CMP_PWR];
      validThresh <= pwdata[SUP_VTH_LSB +: VTH_W];
      detectMethod <= pwdata[SUP_DET_METHOD];
      runWithSupply <= pwdata[SUP_RUN_CONV];
      brownoutShutdownEn <= pwdata[SUP_BO_SHDN];
    end
  end

  // Core, analog and io rails
  genvar r;
  generate
    for (r = 0; r < NRAIL; r++) begin : g_rail
      logic [TRG_W-1:0] linCode;
      // A margin above the target floors the threshold at code zero
      wire marginFits = (railTrg[r] >= TRG_W'(railMgn[r]));
      wire [TRG_W-1:0] boCode = marginFits ? railTrg[r] - TRG_W'(railMgn[r]) : '0;

      pmu_code_adjust #(.W(TRG_W)) u_adj (
        .target(railTrg[r]),
        .offsetSel(railOfs[r]),
        .linear(linCode)
      );

      always_comb begin
        rdRail[r] = RST_ZERO;
        rdRail[r][RAIL_TRG_LSB +: TRG_W] = railTrg[r];
        rdRail[r][RAIL_OFS_LSB +: OFS_W] = railOfs[r];
        rdRail[r][RAIL_MGN_LSB +: MGN_W] = railMgn[r];
        rdRail[r][RAIL_LIN_ON] = railLin[r];
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          railTrg[r] <= '0;
          railOfs[r] <= OFS_EQUAL;
          railMgn[r] <= '0;
          railLin[r] <= 1'b0;
        end else if (wrEn && hitRail[r]) begin
          railTrg[r] <= pwdata[RAIL_TRG_LSB +: TRG_W];
          railOfs[r] <= pwdata[RAIL_OFS_LSB +: OFS_W];
          railMgn[r] <= pwdata[RAIL_MGN_LSB +: MGN_W];
          railLin[r] <= pwdata[RAIL_LIN_ON];
        end
      end

      // Regulator drive; the converter code is the bare target
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          railTargetCode[r*TRG_W +: TRG_W] <= '0;
          linearTargetCode[r*TRG_W +: TRG_W] <= '0;
          railBrownoutCode[r*TRG_W +: TRG_W] <= '0;
          linearRegulatorOn[r] <= 1'b0;
        end else begin
          railTargetCode[r*TRG_W +: TRG_W] <= railTrg[r];
          linearTargetCode[r*TRG_W +: TRG_W] <= linCode;
          railBrownoutCode[r*TRG_W +: TRG_W] <= boCode;
          linearRegulatorOn[r] <= next_linearRegulatorOn[r];
        end
      end
    end
  endgenerate

  // Memory rail; the bring-up order and ramp wait are left to software
  // Limiter resets on, so an early enable still ramps limited
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      memTrg <= '0;
      memPulldown <= 1'b0;
      memLinOn <= 1'b0;
      memIlimit <= 1'b1;
    end else if (wrEn && hitMemory) begin
      memTrg <= pwdata[RAIL_TRG_LSB +: TRG_W];
      memPulldown <= pwdata[MEM_PULLDOWN];
      memLinOn <= pwdata[MEM_LIN_ON];
      memIlimit <= pwdata[MEM_ILIMIT];
    end
  end

  // Four-two rail and battery brownout level
  // Codes above battery-matching are stored; software avoids them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fttTrg <= FTT_4V2;
      battLevel <= '0;
    end else begin
      if (wrEn && hitFourTwo) begin
        fttTrg <= pwdata[FTT_W-1:0];
      end
      if (wrEn && hitBattery) begin
        battLevel <= pwdata[BBL_W-1:0];
      end
    end
  end

  // Key-protected master switch
  // Only bit zero is kept; the key is never stored
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerDownOff <= 1'b0;
    end else if (shutdownWr) begin
      powerDownOff <= pwdata[SHDN_PD_OFF];
    end
  end

  // Hardware-set state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fivePresent <= 1'b0;
      railBoFlag <= '0;
      battBoFlag <= 1'b0;
      powerDownReq <= 1'b0;
      deviceResetReq <= 1'b0;
    end else begin
      fivePresent <= next_fivePresent;
      railBoFlag <= next_railBoFlag;
      battBoFlag <= next_battBoFlag;
      powerDownReq <= next_powerDownReq;
      deviceResetReq <= next_deviceResetReq;
    end
  end

  // Control outputs
  // Converter resets on: with no supply known it is the only source
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      supplyCmpPowerUp <= 1'b0;
      supplyValidThresholdSelect <= '0;
      converterOn <= 1'b1;
      memoryRailTargetCode <= '0;
      memoryRailOn <= 1'b0;
      memoryRailPulldown <= 1'b0;
      inrushLimiterOn <= 1'b1;
      fourPointTwoTargetCode <= FTT_4V2;
      batteryBrownoutLevel <= '0;
    end else begin
      supplyCmpPowerUp <= cmpPowerUp;
      supplyValidThresholdSelect <= validThresh;
      converterOn <= next_converterOn;
      memoryRailTargetCode <= memTrg;
      memoryRailOn <= memLinOn;
      memoryRailPulldown <= memPulldown;
      inrushLimiterOn <= memIlimit;
      fourPointTwoTargetCode <= fttTrg;
      batteryBrownoutLevel <= battLevel;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pmu_sync.sv
// Purpose: Two-stage synchroniser for asynchronous comparator levels.
// Assumes: Inputs are slow levels; no pulse shorter than two clocks matters.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none
module pmu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Levels
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      synced <= '0;
    end else begin
      meta <= async;
      synced <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== pkg/pmu_pkg.sv
// Purpose: Shared constants for the rail and brownout controller.
// Assumes: APB with 32-bit data, byte addresses, one register per aligned word.
// Notes: Voltages are in millivolts; codes are steps above a base.
package pmu_pkg;
  // Field widths
  localparam int TRG_W = 5;
  localparam int VTH_W = 3;
  localparam int OFS_W = 2;
  localparam int MGN_W = 3;
  localparam int FTT_W = 3;
  localparam int BBL_W = 5;
  localparam int NRAIL = 3;
  // Register byte offsets
  localparam logic [7:0] ADDR_SUPPLY = 8'h00;
  localparam logic [7:0] ADDR_CORE = 8'h10;
  localparam logic [7:0] ADDR_ANALOG = 8'h14;
  localparam logic [7:0] ADDR_IO = 8'h18;
  localparam logic [7:0] ADDR_MEMORY = 8'h20;
  localparam logic [7:0] ADDR_FOURTWO = 8'h24;
  localparam logic [7:0] ADDR_BATTERY = 8'h28;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'h2C;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  // Supply control fields
  localparam int SUP_CMP_PWR = 0;
  localparam int SUP_VTH_LSB = 1;
  localparam int SUP_DET_METHOD = 4;
  localparam int SUP_RUN_CONV = 5;
  localparam int SUP_BO_SHDN = 6;
  // Rail control fields
  localparam int RAIL_TRG_LSB = 0;
  localparam int RAIL_OFS_LSB = 8;
  localparam int RAIL_MGN_LSB = 12;
  localparam int RAIL_LIN_ON = 16;
  // Memory rail fields
  localparam int MEM_PULLDOWN = 8;
  localparam int MEM_LIN_ON = 9;
  localparam int MEM_ILIMIT = 10;
  // Shutdown register fields
  localparam int SHDN_PD_OFF = 0;
  localparam int SHDN_KEY_LSB = 16;
  // Status fields
  localparam int STA_SUPPLY = 0;
  localparam int STA_CONV = 1;
  localparam int STA_RAIL_BO = 2;
  localparam int STA_BATT_BO = 5;
  // Unlock key, value is arbitrary
  localparam logic [15:0] SHDN_KEY = 16'h5A3C;
  // Offset selector codes
  localparam logic [OFS_W-1:0] OFS_EQUAL = 2'h0;
  localparam logic [OFS_W-1:0] OFS_ABOVE = 2'h1;
  localparam logic [OFS_W-1:0] OFS_BELOW = 2'h2;
  // Four-two rail level codes
  localparam logic [FTT_W-1:0] FTT_4V2 = 3'h0;
  localparam logic [FTT_W-1:0] FTT_4V1 = 3'h1;
  localparam logic [FTT_W-1:0] FTT_4V0 = 3'h2;
  localparam logic [FTT_W-1:0] FTT_3V9 = 3'h3;
  localparam logic [FTT_W-1:0] FTT_BATT = 3'h4;
  // Analog scaling seen by the regulators
  localparam int CORE_BASE_MV = 800;
  localparam int RAIL_STEP_MV = 25;
  localparam int MEM_BASE_MV = 1700;
  localparam int MEM_STEP_MV = 50;
  localparam int BATT_BASE_MV = 2400;
  localparam int BATT_STEP_MV = 40;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

// ===== sim/pmu_analog_model.sv
// Purpose: Behavioural comparators of the analog side.
// Assumes: Voltages in millivolts set by the bench.
// Notes: All three rails share the core base, so one rail voltage serves all.
`timescale 1ns/1ns
`default_nettype none
module pmu_analog_model
  import pmu_pkg::*;
#(
  parameter int VALID_BASE_MV = 4000,
  parameter int VALID_STEP_MV = 100,
  parameter int IO_MV = 3300
) (
  // From the controller
  input wire logic supplyCmpPowerUp,
  input wire logic [VTH_W-1:0] supplyValidThresholdSelect,
  input wire logic [NRAIL*TRG_W-1:0] railBrownoutCode,
  input wire logic [BBL_W-1:0] batteryBrownoutLevel,
  // Measured levels
  input wire logic [15:0] supplyMv,
  input wire logic [15:0] battMv,
  input wire logic [15:0] railMv,
  // Comparators
  output logic supplyValidRaw,
  output logic supplyAboveIoRaw,
  output logic [NRAIL-1:0] railBrownoutRaw,
  output logic batteryBrownoutRaw
);
  // An unpowered comparator reads low
  assign supplyValidRaw = supplyCmpPowerUp &&
    (int'(supplyMv) > VALID_BASE_MV + VALID_STEP_MV * int'(supplyValidThresholdSelect));
  assign supplyAboveIoRaw = int'(supplyMv) > IO_MV;
  assign batteryBrownoutRaw = int'(battMv) <= BATT_BASE_MV + BATT_STEP_MV * int'(batteryBrownoutLevel);
  for (genvar r = 0; r < NRAIL; r++) begin : g_rail
    assign railBrownoutRaw[r] = int'(railMv) <=
      CORE_BASE_MV + RAIL_STEP_MV * int'(railBrownoutCode[r*TRG_W +: TRG_W]);
  end
endmodule
`default_nettype wire

// ===== sim/pmu_rail_ctrl_props.sv
// Purpose: Port-level checks of the rail controller.
// Assumes: One clock domain; APB slave answers with zero wait states.
// Notes: Shadow flags track accepted writes seen on the bus.
`timescale 1ns/1ns
`default_nettype none
module pmu_rail_ctrl_props
  import pmu_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic supplyValidRaw,
  input wire logic supplyAboveIoRaw,
  input wire logic hwResetReqRaw,
  input wire logic watchdogReset,
  input wire logic converterOn,
  input wire logic memoryRailOn,
  input wire logic inrushLimiterOn,
  input wire logic powerDownReq,
  input wire logic deviceResetReq
);
  logic acc;
  logic shadow;
  logic memOn;
  logic ilimClr;
  logic [3:0] quietCnt;
  logic [3:0] hwCnt;
  assign acc = psel & penable & pready & pwrite;
  // Counters saturate so long quiet spells never wrap back to zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow <= 1'b0;
      memOn <= 1'b0;
      ilimClr <= 1'b0;
      quietCnt <= 4'h0;
      hwCnt <= 4'h0;
    end else begin
      if (acc && paddr == ADDR_SHUTDOWN && pwdata[31:16] == SHDN_KEY) shadow <= pwdata[SHDN_PD_OFF];
      if (acc && paddr == ADDR_MEMORY && pwdata[MEM_LIN_ON]) memOn <= 1'b1;
      if (acc && paddr == ADDR_MEMORY && !pwdata[MEM_ILIMIT]) ilimClr <= 1'b1;
      quietCnt <= (supplyValidRaw | supplyAboveIoRaw) ? 4'h0 : quietCnt + 4'(quietCnt != 4'hF);
      hwCnt <= !hwResetReqRaw ? 4'h0 : hwCnt + 4'(hwCnt != 4'hF);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  conv_default_a: assert property (quietCnt >= 4'h5 |-> converterOn)
    else $error("converter off without supply");
  mem_off_a: assert property (!memOn |-> !memoryRailOn)
    else $error("memory rail on before enable");
  ilim_set_a: assert property (!ilimClr |-> inrushLimiterOn)
    else $error("inrush limiter off before clear");
  wdog_reset_a: assert property (watchdogReset |=> deviceResetReq)
    else $error("watchdog reset lost");
  pd_blocked_a: assert property (shadow && $past(shadow) |-> !powerDownReq)
    else $error("power down while blocked");
  hw_reset_a: assert property (hwCnt >= 4'h5 && !shadow && !$past(shadow) |-> deviceResetReq)
    else $error("hardware reset request lost");
  cover property (pslverr);
  cover property (powerDownReq);
  cover property (memoryRailOn && !inrushLimiterOn);
endmodule
bind pmu_rail_ctrl pmu_rail_ctrl_props pmu_rail_ctrl_props_inst (.sys_clk(sys_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .supplyValidRaw(supplyValidRaw), .supplyAboveIoRaw(supplyAboveIoRaw),
  .hwResetReqRaw(hwResetReqRaw), .watchdogReset(watchdogReset), .converterOn(converterOn),
  .memoryRailOn(memoryRailOn), .inrushLimiterOn(inrushLimiterOn), .powerDownReq(powerDownReq),
  .deviceResetReq(deviceResetReq));
`default_nettype wire

// ===== sim/tb_pmu_rail_and_brownout_control.sv
// Purpose: Self-checking bench for the rail controller.
// Assumes: APB master waits for pready; analog side modelled.
// Notes: Memory ramp wait is the full 500 us at 8 ns.
`timescale 1ns/1ns
`default_nettype none
module tb_pmu_rail_and_brownout_control;
  import pmu_pkg::*;
  localparam int RAMP_CYCLES = 500_000 / 8;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, rdErr, hwResetReqRaw, watchdogReset;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic supplyValidRaw, supplyAboveIoRaw, batteryBrownoutRaw, supplyCmpPowerUp, converterOn;
  logic memoryRailOn, memoryRailPulldown, inrushLimiterOn, powerDownReq, deviceResetReq;
  logic [NRAIL-1:0] railBrownoutRaw, linearRegulatorOn;
  logic [VTH_W-1:0] supplyValidThresholdSelect;
  logic [NRAIL*TRG_W-1:0] railTargetCode, linearTargetCode, railBrownoutCode;
  logic [TRG_W-1:0] memoryRailTargetCode;
  logic [FTT_W-1:0] fourPointTwoTargetCode;
  logic [BBL_W-1:0] batteryBrownoutLevel;
  logic [15:0] supplyMv, battMv, railMv;
  int n_errors, checked;
  // 4050 mV lies between the io level and the selected valid level
  logic [31:0] supTab [4] = '{32'h0000_0013, 32'h0000_0003, 32'h0000_0013, 32'h0000_0012};
  logic [15:0] mvTab [4] = '{16'h0FD2, 16'h0FD2, 16'h1388, 16'h1388};
  logic convTab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [OFS_W-1:0] ofsTab [3] = '{OFS_EQUAL, OFS_ABOVE, OFS_BELOW};
  logic [TRG_W-1:0] linTab [3] = '{5'h1A, 5'h1B, 5'h19};
  pmu_rail_ctrl pmu_rail_ctrl_inst (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supplyValidRaw(supplyValidRaw), .supplyAboveIoRaw(supplyAboveIoRaw), .railBrownoutRaw(railBrownoutRaw),
    .batteryBrownoutRaw(batteryBrownoutRaw), .hwResetReqRaw(hwResetReqRaw), .watchdogReset(watchdogReset),
    .supplyCmpPowerUp(supplyCmpPowerUp), .supplyValidThresholdSelect(supplyValidThresholdSelect),
    .converterOn(converterOn), .linearRegulatorOn(linearRegulatorOn), .railTargetCode(railTargetCode),
    .linearTargetCode(linearTargetCode), .railBrownoutCode(railBrownoutCode),
    .memoryRailTargetCode(memoryRailTargetCode), .memoryRailOn(memoryRailOn),
    .memoryRailPulldown(memoryRailPulldown), .inrushLimiterOn(inrushLimiterOn),
    .fourPointTwoTargetCode(fourPointTwoTargetCode), .batteryBrownoutLevel(batteryBrownoutLevel),
    .powerDownReq(powerDownReq), .deviceResetReq(deviceResetReq));
  pmu_analog_model pmu_analog_model_inst (.supplyCmpPowerUp(supplyCmpPowerUp),
    .supplyValidThresholdSelect(supplyValidThresholdSelect), .railBrownoutCode(railBrownoutCode),
    .batteryBrownoutLevel(batteryBrownoutLevel), .supplyMv(supplyMv), .battMv(battMv), .railMv(railMv),
    .supplyValidRaw(supplyValidRaw), .supplyAboveIoRaw(supplyAboveIoRaw), .railBrownoutRaw(railBrownoutRaw),
    .batteryBrownoutRaw(batteryBrownoutRaw));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("checked=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim();
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Covers two sync stages, the register stage and the derived output
  task automatic settle;
    repeat (8) @(negedge sys_clk);
  endtask
  initial begin
    int k;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    hwResetReqRaw = 1'b0; watchdogReset = 1'b0; supplyMv = 16'h0000; battMv = 16'h0FA0; railMv = 16'h05AA;
    arst_n = 1'b0; n_errors = 0; checked = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    chk(converterOn, 1'b1);
    chk(memoryRailOn, 1'b0);
    chk(inrushLimiterOn, 1'b1);
    chk(fourPointTwoTargetCode, FTT_4V2);
    apb(1'b0, ADDR_MEMORY, 32'h0000_0000);
    chk(rdData, 32'h0000_0400);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk(rdErr, 1'b1);
    chk(rdData, 32'h0000_0000);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      supplyMv <= mvTab[k];
      apb(1'b1, ADDR_SUPPLY, supTab[k]);
      settle();
      chk(converterOn, convTab[k]);
      chk(linearRegulatorOn, convTab[k] ? 3'h0 : 3'h7);
    end
    $display("test detect done");
    for (k = 0; k < NRAIL; k++) apb(1'b1, ADDR_CORE + 8'(4 * k), 32'h0000_421A);
    apb(1'b1, ADDR_SUPPLY, 32'h0000_0033);
    settle();
    chk(converterOn, 1'b1);
    chk(linearRegulatorOn, 3'h0);
    chk(railTargetCode, {3{5'h1A}});
    chk(linearTargetCode, {3{5'h19}});
    chk(railBrownoutCode, {3{5'h16}});
    apb(1'b1, ADDR_CORE, 32'h0001_421A);
    settle();
    chk(linearRegulatorOn, 3'h1);
    for (k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_CORE, {16'h0000, 4'h4, 2'h0, ofsTab[k], 8'h1A});
      settle();
      chk(linearTargetCode[TRG_W-1:0], linTab[k]);
    end
    $display("test rails done");
    apb(1'b1, ADDR_MEMORY, 32'h0000_0502);
    settle();
    chk(memoryRailPulldown, 1'b1);
    chk({memoryRailOn, memoryRailTargetCode}, 6'h02);
    apb(1'b1, ADDR_MEMORY, 32'h0000_0702);
    settle();
    chk(memoryRailOn, 1'b1);
    repeat (RAMP_CYCLES) @(posedge sys_clk);
    apb(1'b1, ADDR_MEMORY, 32'h0000_0302);
    settle();
    chk({memoryRailOn, inrushLimiterOn}, 2'h2);
    apb(1'b1, ADDR_FOURTWO, 32'(FTT_BATT));
    settle();
    chk(fourPointTwoTargetCode, FTT_BATT);
    $display("test memory done");
    apb(1'b1, ADDR_BATTERY, 32'h0000_0014);
    apb(1'b1, ADDR_SHUTDOWN, {SHDN_KEY, 16'h0001});
    apb(1'b1, ADDR_SUPPLY, 32'h0000_0073);
    @(posedge sys_clk);
    battMv <= 16'(BATT_BASE_MV + BATT_STEP_MV * 20);
    railMv <= 16'(CORE_BASE_MV + RAIL_STEP_MV * 22);
    hwResetReqRaw <= 1'b1;
    settle();
    chk(batteryBrownoutLevel, 5'h14);
    chk({powerDownReq, deviceResetReq}, 2'h0);
    apb(1'b1, ADDR_SHUTDOWN, 32'h0000_0000);
    settle();
    chk(powerDownReq, 1'b0);
    apb(1'b0, ADDR_SHUTDOWN, 32'h0000_0000);
    chk(rdData, 32'h0000_0001);
    apb(1'b1, ADDR_SHUTDOWN, {SHDN_KEY, 16'h0000});
    settle();
    chk({powerDownReq, deviceResetReq}, 2'h3);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdData[STA_BATT_BO:STA_RAIL_BO], 4'hF);
    @(posedge sys_clk);
    hwResetReqRaw <= 1'b0;
    apb(1'b1, ADDR_SHUTDOWN, {SHDN_KEY, 16'h0001});
    @(posedge sys_clk);
    watchdogReset <= 1'b1;
    settle();
    chk({powerDownReq, deviceResetReq}, 2'h1);
    $display("test shutdown done");
    end_sim();
  end
endmodule
`default_nettype wire
